// *** rtl/reset_source_controller.sv ***
// Reset source controller: combines reset sources, runs start-up delay, keeps reset cause
`timescale 1ns/1ns
`default_nettype none

module reset_source_controller #(
  parameter int OSC_TICKS_LONG = reset_seq_pkg::OSC_TICKS_LONG,
  parameter int OSC_TICKS_MID = reset_seq_pkg::OSC_TICKS_MID
) (
  // Clock and block reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous reset sources and oscillator
  input wire logic por_below,
  input wire logic reset_pin_n,
  input wire logic bod_below,
  input wire logic wdt_osc_clk,
  // Fuses, high when programmed
  input wire logic [1:0] startup_delay_select,
  input wire logic brownout_enable_fuse,
  input wire logic brownout_level_fuse,
  // Same-clock requests
  input wire logic watchdog_timeout,
  input wire logic powerdown_wake,
  input wire logic converter_enable,
  // Outputs to core and analog
  output logic core_reset,
  output logic wake_hold,
  output logic watchdog_reset_pulse,
  output logic brownout_level_high,
  output logic bandgap_enable
);

  // Synchroniser stages for all asynchronous inputs
  logic [7:0] sync_meta;
  logic [7:0] sync_q;
  // Synchronised views
  logic por_s;
  logic pin_low_s;
  logic bod_s;
  logic osc_s;
  logic [1:0] delay_sel_s;
  logic bod_en_s;
  logic bod_lvl_s;
  // Oscillator edge detection
  logic osc_prev;
  logic osc_tick;
  // Brown-out dip filter
  logic [6:0] bod_dip_count;
  logic [6:0] bod_dip_limit;
  logic bod_event;
  // Sequencer
  reset_seq_pkg::seq_state_t state;
  reset_seq_pkg::seq_state_t next_state;
  logic sources_any;
  logic [16:0] osc_count;
  logic [4:0] clk_count;
  // Register contents
  logic [3:0] cause;
  logic cmp_bandgap_sel;
  // Bus qualifiers
  logic bus_setup;
  logic bus_write;

  // Oscillator tick count for a fuse setting
  function automatic logic [16:0] osc_ticks(input logic [1:0] sel, input logic bod_en);
    logic [16:0] n;
    n = 17'(OSC_TICKS_LONG);
    if (sel == reset_seq_pkg::SEL_MID)
    begin
      n = 17'(OSC_TICKS_MID);
    end
    else if (sel == reset_seq_pkg::SEL_SHORT)
    begin
      // Longer short delay when brown-out detection is on
      n = bod_en ? 17'(reset_seq_pkg::OSC_TICKS_BOD) : 17'(reset_seq_pkg::OSC_TICKS_SHORT);
    end
    return n;
  endfunction

  // Address match for a mapped register
  function automatic logic is_mapped(input logic [7:0] addr);
    return (addr == reset_seq_pkg::RESET_CAUSE_OFFSET) || (addr == reset_seq_pkg::BANDGAP_CTRL_OFFSET);
  endfunction

  // Two-flop synchroniser, no logic reads the first stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_meta <= 8'h00;
      sync_q <= 8'h00;
    end
    else
    begin
      sync_meta <= {por_below, ~reset_pin_n, bod_below, wdt_osc_clk,
                    startup_delay_select, brownout_enable_fuse, brownout_level_fuse};
      sync_q <= sync_meta;
    end
  end

  // Named views of the synchronised inputs
  assign por_s = sync_q[7];
  assign pin_low_s = sync_q[6];
  assign bod_s = sync_q[5];
  assign osc_s = sync_q[4];
  assign delay_sel_s = sync_q[3:2];
  assign bod_en_s = sync_q[1];
  assign bod_lvl_s = sync_q[0];

  // Oscillator rising edge becomes a one-cycle tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_prev <= 1'b0;
    end
    else
    begin
      osc_prev <= osc_s;
    end
  end

  assign osc_tick = osc_s & ~osc_prev;

  // Dip length needed per trigger level
  assign bod_dip_limit = bod_lvl_s ? 7'(reset_seq_pkg::BOD_DIP_HIGH_CYCLES)
                                   : 7'(reset_seq_pkg::BOD_DIP_LOW_CYCLES);

  // Brown-out dip filter, only long dips count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bod_dip_count <= 7'h00;
      bod_event <= 1'b0;
    end
    else if (!bod_en_s || !bod_s)
    begin
      // Detector disabled or supply recovered
      bod_dip_count <= 7'h00;
      bod_event <= 1'b0;
    end
    else if (bod_dip_count < bod_dip_limit)
    begin
      // Still inside the ignored window
      bod_dip_count <= bod_dip_count + 7'h01;
    end
    else
    begin
      // Long dip: brown-out reset
      bod_event <= 1'b1;
    end
  end

  // Trigger level follows the level fuse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brownout_level_high <= 1'b0;
    end
    else
    begin
      brownout_level_high <= bod_lvl_s;
    end
  end

  // Watchdog time-out becomes a one-cycle pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      watchdog_reset_pulse <= 1'b0;
    end
    else
    begin
      watchdog_reset_pulse <= watchdog_timeout & ~watchdog_reset_pulse;
    end
  end

  // Any source still active
  assign sources_any = por_s | pin_low_s | bod_event | watchdog_reset_pulse;

  // Next-state logic of the start-up sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      reset_seq_pkg::ST_RUN:
      begin
        if (sources_any)
        begin
          next_state = reset_seq_pkg::ST_HOLD;
        end
        else if (powerdown_wake)
        begin
          // Wake skips the oscillator part
          next_state = reset_seq_pkg::ST_WAKE;
        end
      end
      reset_seq_pkg::ST_HOLD:
      begin
        if (!sources_any)
        begin
          // Last source gone, start the delay
          next_state = reset_seq_pkg::ST_OSC;
        end
      end
      reset_seq_pkg::ST_OSC:
      begin
        if (sources_any)
        begin
          next_state = reset_seq_pkg::ST_HOLD;
        end
        else if (osc_count == 17'h0_0000)
        begin
          next_state = reset_seq_pkg::ST_CLK;
        end
      end
      reset_seq_pkg::ST_CLK, reset_seq_pkg::ST_WAKE:
      begin
        if (sources_any)
        begin
          next_state = reset_seq_pkg::ST_HOLD;
        end
        else if (clk_count == 5'h01)
        begin
          next_state = reset_seq_pkg::ST_RUN;
        end
      end
      default:
      begin
        next_state = reset_seq_pkg::ST_HOLD;
      end
    endcase
  end

  // State register, held in reset from block reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= reset_seq_pkg::ST_HOLD;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Oscillator part counter, loaded while held
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_count <= 17'h0_0000;
    end
    else if (state != reset_seq_pkg::ST_OSC)
    begin
      osc_count <= osc_ticks(delay_sel_s, bod_en_s);
    end
    else if (osc_tick && osc_count != 17'h0_0000)
    begin
      osc_count <= osc_count - 17'h0_0001;
    end
  end

  // Clock part counter, 18 cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_count <= 5'h00;
    end
    else if (state != reset_seq_pkg::ST_CLK && state != reset_seq_pkg::ST_WAKE)
    begin
      clk_count <= 5'(reset_seq_pkg::STARTUP_CLOCKS);
    end
    else
    begin
      clk_count <= clk_count - 5'h01;
    end
  end

  // Core reset and wake hold from the next state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_reset <= 1'b1;
      wake_hold <= 1'b0;
    end
    else
    begin
      // Held while any source or start-up delay runs; low during the wake delay
      core_reset <= (next_state != reset_seq_pkg::ST_RUN) && (next_state != reset_seq_pkg::ST_WAKE);
      wake_hold <= next_state == reset_seq_pkg::ST_WAKE;
    end
  end

  // Bus phase qualifiers
  assign bus_setup = psel & ~penable;
  assign bus_write = psel & penable & pready & pwrite;

  // Cause flags, set wins over software clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cause <= reset_seq_pkg::CAUSE_RESET;
    end
    else
    begin
      if (bus_write && paddr == reset_seq_pkg::RESET_CAUSE_OFFSET)
      begin
        // Writing zero clears, writing one keeps
        cause <= cause & pwdata[3:0];
      end
      // Flags persist through core reset
      if (por_s)
      begin
        // Power-on clears others, sets own flag
        cause[reset_seq_pkg::WATCHDOG_FLAG_BIT] <= 1'b0;
        cause[reset_seq_pkg::BROWNOUT_FLAG_BIT] <= 1'b0;
        cause[reset_seq_pkg::PIN_FLAG_BIT] <= 1'b0;
        cause[reset_seq_pkg::POWERUP_FLAG_BIT] <= 1'b1;
      end
      else
      begin
        // Each source marks its own flag
        if (watchdog_reset_pulse)
        begin
          cause[reset_seq_pkg::WATCHDOG_FLAG_BIT] <= 1'b1;
        end
        if (bod_event)
        begin
          cause[reset_seq_pkg::BROWNOUT_FLAG_BIT] <= 1'b1;
        end
        if (pin_low_s)
        begin
          cause[reset_seq_pkg::PIN_FLAG_BIT] <= 1'b1;
        end
      end
    end
  end

  // Comparator bandgap select bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_bandgap_sel <= reset_seq_pkg::CMP_BANDGAP_SEL_RESET;
    end
    else if (bus_write && paddr == reset_seq_pkg::BANDGAP_CTRL_OFFSET)
    begin
      cmp_bandgap_sel <= pwdata[reset_seq_pkg::CMP_BANDGAP_SEL_BIT];
    end
  end

  // Bandgap reference enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bandgap_enable <= 1'b0;
    end
    else
    begin
      bandgap_enable <= bod_en_s | cmp_bandgap_sel | converter_enable;
    end
  end

  // APB answer: one access cycle, error on unmapped address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= bus_setup;
      pslverr <= bus_setup & ~is_mapped(paddr);
      prdata <= 32'h0000_0000;
      if (bus_setup && !pwrite && paddr == reset_seq_pkg::RESET_CAUSE_OFFSET)
      begin
        // Upper bits read as zero
        prdata <= {28'h000_0000, cause};
      end
      else if (bus_setup && !pwrite && paddr == reset_seq_pkg::BANDGAP_CTRL_OFFSET)
      begin
        prdata <= {31'h0000_0000, cmp_bandgap_sel};
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/reset_seq_pkg.sv ***
// Constants, register map and state encoding of the reset source controller
package reset_seq_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] RESET_CAUSE_OFFSET = 8'h34;
  localparam logic [7:0] BANDGAP_CTRL_OFFSET = 8'h30;

  // Reset cause register fields
  localparam int WATCHDOG_FLAG_BIT = 3;
  localparam int BROWNOUT_FLAG_BIT = 2;
  localparam int PIN_FLAG_BIT = 1;
  localparam int POWERUP_FLAG_BIT = 0;
  localparam logic [3:0] CAUSE_RESET = 4'h0;

  // Bandgap control register fields
  localparam int CMP_BANDGAP_SEL_BIT = 0;
  localparam logic CMP_BANDGAP_SEL_RESET = 1'b0;

  // Clock period and brown-out dip filter times
  localparam int CLK_PERIOD_NS = 100;
  localparam int BOD_DIP_HIGH_NS = 3000;
  localparam int BOD_DIP_LOW_NS = 7000;
  localparam int BOD_DIP_HIGH_CYCLES = (BOD_DIP_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOD_DIP_LOW_CYCLES = (BOD_DIP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Start-up delay parts
  localparam int STARTUP_CLOCKS = 18;
  localparam int OSC_TICKS_LONG = 65536;
  localparam int OSC_TICKS_MID = 4096;
  localparam int OSC_TICKS_BOD = 32;
  localparam int OSC_TICKS_SHORT = 8;

  // Start-up delay select fuse codes
  localparam logic [1:0] SEL_MID = 2'b10;
  localparam logic [1:0] SEL_SHORT = 2'b11;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_RUN = 5'b00001,
    ST_HOLD = 5'b00010,
    ST_OSC = 5'b00100,
    ST_CLK = 5'b01000,
    ST_WAKE = 5'b10000
  } seq_state_t;

endpackage

// *** tb/reset_checker_sva.sv ***
// Port checker for the reset source controller
`timescale 1ns/1ns
`default_nettype none
module reset_checker #(
  parameter int OSC_TICKS_LONG = 16,
  parameter int OSC_TICKS_MID = 12
) (
  // Clock and block reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus side
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Reset sources and requests
  input wire logic por_below,
  input wire logic reset_pin_n,
  input wire logic watchdog_timeout,
  input wire logic converter_enable,
  input wire logic brownout_level_fuse,
  // Outputs to core and analog
  input wire logic core_reset,
  input wire logic wake_hold,
  input wire logic watchdog_reset_pulse,
  input wire logic brownout_level_high,
  input wire logic bandgap_enable
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Cycles since the last pin, supply or watchdog event
  logic [7:0] quiet_cnt;
  // Counts up while no power-on, pin or watchdog source is active
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      quiet_cnt <= 8'h00;
    else if (por_below || !reset_pin_n || watchdog_reset_pulse)
      quiet_cnt <= 8'h00;
    else if (quiet_cnt != 8'hff)
      quiet_cnt <= quiet_cnt + 8'h01;
  end
  // Wake hold lasts exactly eighteen cycles
  sequence wake_span;
    ##17 wake_hold ##1 !wake_hold;
  endsequence
  chk_por_holds:
    assert property (por_below [*4] |-> core_reset) else $error("core reset low under supply fault");
  chk_pin_holds:
    assert property (!reset_pin_n [*4] |-> core_reset) else $error("core reset low with pin low");
  chk_release_wait:
    assert property ($fell(core_reset) |-> quiet_cnt > 8'h12) else $error("core released too early");
  chk_pulse_cause:
    assert property (watchdog_reset_pulse |-> $past(watchdog_timeout) ##1 core_reset)
      else $error("watchdog pulse without cause");
  chk_pulse_single:
    assert property (watchdog_reset_pulse |=> !watchdog_reset_pulse) else $error("watchdog pulse too long");
  chk_wake_span:
    assert property ($rose(wake_hold) |-> !core_reset ##0 wake_span) else $error("wake hold length wrong");
  chk_bandgap_conv:
    assert property (converter_enable [*2] |-> bandgap_enable) else $error("bandgap off with converter");
  chk_level_high:
    assert property (brownout_level_fuse [*5] |-> brownout_level_high) else $error("trigger level not high");
  chk_level_low:
    assert property (!brownout_level_fuse [*5] |-> !brownout_level_high) else $error("trigger level not low");
  chk_bad_addr:
    assert property (pready && paddr != 8'h30 && paddr != 8'h34 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
  chk_cause_upper:
    assert property (pready && paddr == 8'h34 |-> prdata[31:4] == 28'h0) else $error("cause upper bits set");
endmodule
bind reset_source_controller reset_checker #(.OSC_TICKS_LONG(OSC_TICKS_LONG), .OSC_TICKS_MID(OSC_TICKS_MID)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .por_below(por_below), .reset_pin_n(reset_pin_n),
  .watchdog_timeout(watchdog_timeout), .converter_enable(converter_enable),
  .brownout_level_fuse(brownout_level_fuse), .core_reset(core_reset), .wake_hold(wake_hold),
  .watchdog_reset_pulse(watchdog_reset_pulse), .brownout_level_high(brownout_level_high),
  .bandgap_enable(bandgap_enable));
`default_nettype wire

// *** tb/source_model.sv ***
// Model of the supply detectors, reset pin and watchdog oscillator
`timescale 1ns/1ns
`default_nettype none
module source_model (
  // Clock
  input wire logic pclk,
  // Detector and pin levels
  output var logic por_below,
  output var logic reset_pin_n,
  output var logic bod_below,
  // Free-running oscillator
  output var logic wdt_osc_clk
);
  // Supply starts below the power-on level
  initial
  begin
    por_below = 1'b1;
    reset_pin_n = 1'b1;
    bod_below = 1'b0;
    wdt_osc_clk = 1'b0;
  end
  // Oscillator runs free, unrelated in phase to pclk
  always #115 wdt_osc_clk = ~wdt_osc_clk;
  // Holds one source active for a number of clocks: 0 supply, 1 pin, 2 dip
  task pulse(input int which, input int cycles);
    @(posedge pclk);
    if (which == 0)
      por_below <= 1'b1;
    else if (which == 1)
      reset_pin_n <= 1'b0;
    else
      bod_below <= 1'b1;
    repeat (cycles) @(posedge pclk);
    por_below <= 1'b0;
    reset_pin_n <= 1'b1;
    bod_below <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench of the reset source controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // Clock, reset and bus
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  // Source levels from the model
  logic por_below, reset_pin_n, bod_below, wdt_osc_clk;
  // Fuses and same-clock requests
  logic [1:0] sel;
  logic bod_en, bod_lvl, wdt_to, wake, conv;
  // Design outputs
  logic core_reset, wake_hold, wdt_pulse, lvl_high, bandgap;
  // Counters
  int fails, checked, n;
  // One bus access and its expected answer
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
  row_t rows[11];

  reset_source_controller #(.OSC_TICKS_LONG(16), .OSC_TICKS_MID(12)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .por_below(por_below),
    .reset_pin_n(reset_pin_n), .bod_below(bod_below), .wdt_osc_clk(wdt_osc_clk),
    .startup_delay_select(sel), .brownout_enable_fuse(bod_en), .brownout_level_fuse(bod_lvl),
    .watchdog_timeout(wdt_to), .powerdown_wake(wake), .converter_enable(conv), .core_reset(core_reset),
    .wake_hold(wake_hold), .watchdog_reset_pulse(wdt_pulse), .brownout_level_high(lvl_high),
    .bandgap_enable(bandgap));
  source_model u_src (.pclk(pclk), .por_below(por_below), .reset_pin_n(reset_pin_n),
    .bod_below(bod_below), .wdt_osc_clk(wdt_osc_clk));

  // 10 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Compares and counts
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Verdict and end of run
  task final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One bus transfer; answer left in rd and er
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    // No answer in time counts as a mismatch
    if (k >= 20)
      fails++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Cycles until the core is released, left in n
  task wait_rel;
    n = 0;
    while (core_reset !== 1'b0 && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  // Hang guard
  initial
  begin
    #2000000;
    fails++;
    final_report;
  end
  // Main sequence
  initial
  begin
    fails = 0;
    checked = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {bod_en, wdt_to, wake, conv} = '0;
    sel = 2'b10;
    bod_lvl = 1'b1;
    rows = '{'{1'b0, 8'h34, 32'h0, 32'h1, 1'b0}, '{1'b1, 8'h34, 32'hffff_ffff, 32'h0, 1'b0},
      '{1'b0, 8'h34, 32'h0, 32'h1, 1'b0}, '{1'b1, 8'h34, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h34, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h30, 32'h1, 32'h0, 1'b0},
      '{1'b0, 8'h30, 32'h0, 32'h1, 1'b0}, '{1'b0, 8'h20, 32'h0, 32'h0, 1'b1},
      '{1'b1, 8'h20, 32'hffff_ffff, 32'h0, 1'b1}, '{1'b0, 8'h34, 32'h0, 32'h0, 1'b0},
      '{1'b1, 8'h30, 32'h0, 32'h0, 1'b0}};
    repeat (5) @(posedge pclk);
    check("core in reset", core_reset, 1'b1);
    presetn <= 1'b1;
    u_src.pulse(0, 10);
    wait_rel;
    check("power-on delay", n >= 40 && n <= 80, 1'b1);
    // Register table rows
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        check("read data", rd, rows[i].q);
      check("slave error", er, rows[i].e);
    end
    // Each bandgap request alone
    for (int k = 0; k < 3; k++)
    begin
      conv <= (k == 0);
      bod_en <= (k == 2);
      if (k == 1)
        apb(1'b1, 8'h30, 32'h1);
      repeat (4) @(posedge pclk);
      check("bandgap on", bandgap, 1'b1);
      conv <= 1'b0;
      bod_en <= 1'b0;
      if (k == 1)
        apb(1'b1, 8'h30, 32'h0);
      repeat (4) @(posedge pclk);
      check("bandgap off", bandgap, 1'b0);
    end
    // Watchdog time-out
    wdt_to <= 1'b1;
    @(posedge pclk);
    wdt_to <= 1'b0;
    @(posedge pclk);
    check("watchdog pulse", wdt_pulse, 1'b1);
    @(posedge pclk);
    check("pulse width", wdt_pulse, 1'b0);
    check("held after pulse", core_reset, 1'b1);
    wait_rel;
    check("watchdog delay", n >= 35 && n <= 80, 1'b1);
    apb(1'b0, 8'h34, 32'h0);
    check("cause watchdog", rd, 32'h8);
    // Pin reset of 600 ns
    u_src.pulse(1, 6);
    wait_rel;
    check("pin delay", n >= 40 && n <= 80, 1'b1);
    apb(1'b0, 8'h34, 32'h0);
    check("cause pin", rd, 32'ha);
    // Brown-out: short dip ignored, long dip resets
    bod_en <= 1'b1;
    u_src.pulse(2, 20);
    repeat (6) @(posedge pclk);
    check("short dip", core_reset, 1'b0);
    u_src.pulse(2, 40);
    check("brown-out reset", core_reset, 1'b1);
    wait_rel;
    check("brown-out delay", n >= 40 && n <= 80, 1'b1);
    apb(1'b0, 8'h34, 32'h0);
    check("cause brown-out", rd, 32'he);
    bod_en <= 1'b0;
    // Power-on clears other flags, pin keeps power flag
    u_src.pulse(0, 6);
    wait_rel;
    apb(1'b0, 8'h34, 32'h0);
    check("cause power-on", rd, 32'h1);
    u_src.pulse(1, 6);
    wait_rel;
    apb(1'b0, 8'h34, 32'h0);
    check("power flag kept", rd, 32'h3);
    // Wake from power-down
    wake <= 1'b1;
    @(posedge pclk);
    wake <= 1'b0;
    n = 0;
    repeat (40)
    begin
      @(posedge pclk);
      if (wake_hold === 1'b1)
        n++;
    end
    check("wake cycles", n, 32'h12);
    check("no core reset", core_reset, 1'b0);
    // Trigger level follows fuse
    check("level high", lvl_high, 1'b1);
    bod_lvl <= 1'b0;
    repeat (5) @(posedge pclk);
    check("level low", lvl_high, 1'b0);
    final_report;
  end
endmodule
`default_nettype wire
